// >>> logic/eca_pkg.sv
// package for the configuration autoload block: offsets, defaults, types
package eca_pkg;
    // image byte addresses
    localparam logic [7:0] IMG_SIGNATURE = 8'h00;
    localparam logic [7:0] IMG_MAC_FIRST = 8'h01;
    localparam logic [7:0] IMG_MAC_LAST = 8'h06;
    localparam logic [7:0] IMG_FS_POLL = 8'h07;
    localparam logic [7:0] IMG_HS_POLL = 8'h08;
    localparam logic [7:0] IMG_CFG_FLAGS = 8'h09;
    localparam logic [7:0] IMG_CFG_THREE = 8'h28;
    localparam logic [7:0] IMG_DIS_SELF = 8'h2A;
    localparam logic [7:0] IMG_DIS_BUS = 8'h2B;
    localparam logic [7:0] IMG_MAX_POWER = 8'h2C;
    localparam logic [7:0] IMG_REMAP_12 = 8'h36;
    localparam logic [7:0] IMG_REMAP_34 = 8'h37;
    localparam logic [7:0] IMG_REMAP_5 = 8'h38;
    localparam logic [7:0] IMG_BOOST_UP = 8'h39;
    localparam logic [7:0] IMG_BOOST_FIVE = 8'h3A;
    localparam logic [7:0] IMG_BOOST_LOW = 8'h3B;
    localparam logic [7:0] IMG_HUB_LAST = 8'h3B;
    localparam logic [7:0] SIGNATURE_VALUE = 8'hA5;
    // register map
    localparam logic [3:0] REG_CONFIG_BYTE_THREE = 4'h0;
    localparam logic [3:0] REG_UPSTREAM_BOOST = 4'h1;
    localparam logic [3:0] REG_PORT_FIVE_BOOST = 4'h2;
    localparam logic [3:0] REG_PORTS_TWO_TO_FOUR_BOOST = 4'h3;
    localparam logic [3:0] REG_STATUS_COMMAND = 4'h4;
    localparam logic [3:0] REG_LOAD_STATUS = 4'h5;
    localparam logic [3:0] REG_PORT_MAP = 4'h6;
    // field positions
    localparam int RENUMBER_BIT = 3;
    localparam int CMD_RESET_BIT = 1;
    localparam int CMD_ATTACH_BIT = 0;
    // hardware defaults
    localparam logic [47:0] DEF_MAC = 48'hFFFF_FFFF_FFFF;
    localparam logic [7:0] DEF_FS_POLL = 8'h01;
    localparam logic [7:0] DEF_HS_POLL = 8'h04;
    localparam logic [7:0] DEF_CFG_FLAGS = 8'h05;
    localparam logic [7:0] DEF_MAX_POWER = 8'h01;
    localparam logic [7:0] DEF_CONFIG_BYTE_THREE = 8'h00;
    localparam logic [7:0] DEF_BOOST = 8'h00;
    localparam logic [7:0] DEF_DISABLE = 8'h00;
    localparam logic [7:0] DEF_REMAP = 8'h00;
    localparam logic [1:0] DEF_STATUS_COMMAND = 2'b01;
    localparam logic [2:0] SYNC_INIT = 3'b000;

    typedef enum logic [1:0] {
        LOAD_NONE,
        LOAD_FULL,
        LOAD_MAC,
        LOAD_ETH
    } eca_load_e;

    typedef enum {
        ST_IDLE,
        ST_SIG_REQ,
        ST_SIG_WAIT,
        ST_BYTE_REQ,
        ST_BYTE_WAIT,
        ST_DONE
    } eca_state_e;

    // request/answer toward the serial memory reader
    typedef struct packed {
        logic req;
        logic [7:0] addr;
    } eca_rom_req_s;

    typedef struct packed {
        logic ack;
        logic [7:0] data;
    } eca_rom_rsp_s;

    // ethernet side configuration
    typedef struct packed {
        logic [47:0] mac;
        logic [7:0] fsPoll;
        logic [7:0] hsPoll;
        logic [7:0] cfgFlags;
        logic [7:0] maxPower;
    } eca_eth_cfg_s;
    localparam eca_eth_cfg_s DEF_ETH_CFG = '{DEF_MAC, DEF_FS_POLL, DEF_HS_POLL, DEF_CFG_FLAGS, DEF_MAX_POWER};

    // last image address of each load kind
    function automatic logic [7:0] eca_last_addr(input eca_load_e kind);
        case (kind)
            LOAD_MAC: return IMG_MAC_LAST;
            LOAD_ETH: return IMG_MAX_POWER;
            default: return IMG_HUB_LAST;
        endcase
    endfunction : eca_last_addr
endpackage : eca_pkg

// >>> logic/eca_autoload.sv
// configuration autoload from serial memory image into hub and ethernet settings
// Summary of operation
// RULE1 - after a loading reset read image byte zero and check signature first
// RULE2 - wrong signature skips loading and keeps hardware defaults
// RULE3 - defaults: mac all ones, polls 01h/04h, flags 05h, power 01h
// RULE4 - usb reset, power-on, external reset, software reset trigger a load
// RULE5 - power-on or external reset loads hub and ethernet settings; the full load here leaves maxPower unloaded
// RULE6 - usb bus reset reloads only the mac address
// RULE7 - software reset or reload loads only ethernet settings
// RULE8 - standard numbering reports own numbers, closing gaps of disabled ports
// RULE9 - standard mode masks come from bytes 2Ah self and 2Bh bus
// RULE10 - remap mode takes port numbers from bytes 36h, 37h, 38h
// RULE11 - upstream boost is a 2-bit field passed to the transceiver
// RULE12 - port five has its own 2-bit boost in low bits
// RULE13 - shared byte holds boosts for ports four, three, two; bits 1:0 reserved
// RULE14 - command reset bit restores defaults and clears itself
// RULE15 - attach bit signals attach and write-protects configuration memory
// RULE16 - attach bit takes one write after reset, default 1
// RULE17 - image byte 28h loads into config byte three
// RULE18 - hold attach and loaded values until the whole portion is written
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module eca_autoload
    import eca_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic usbResetPin,
    input wire logic softwareResetCmd,
    input wire logic reloadCmd,
    output eca_rom_req_s romReq,
    input wire eca_rom_rsp_s romRsp,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic selfPowered,
    output eca_eth_cfg_s ethCfg,
    output logic [1:0] upstreamDriveBoost,
    output logic [1:0] portFiveDriveBoost,
    output logic [1:0] portFourDriveBoost,
    output logic [1:0] portThreeDriveBoost,
    output logic [1:0] portTwoDriveBoost,
    output logic [7:0] portDisableMask,
    output logic [23:0] portRemap,
    output logic portRenumberSelect,
    output logic usbAttach,
    output logic loadBusy
);
    eca_state_e state;
    eca_load_e kind;
    eca_load_e pending;
    logic [7:0] addr;
    logic [2:0] usbSync;
    logic usbSeen;
    logic sigValid;
    logic porPending;
    logic [7:0] configByteThree;
    logic [7:0] upstreamBoost;
    logic [7:0] portFiveBoost;
    logic [7:0] portsTwoToFourBoost;
    logic [7:0] disSelf;
    logic [7:0] disBus;
    logic [7:0] remap12;
    logic [7:0] remap34;
    logic [7:0] remap5;
    logic [1:0] statusCommand;
    logic attachWritten;
    eca_eth_cfg_s ethShadow;
    logic cmdReset;
    logic usbRise;
    logic byteTaken;
    logic writeProtect;

    // pin is asynchronous: rise counts once stages two and three agree
    assign usbRise = usbSync[1] && usbSync[2] && !usbSeen;
    assign byteTaken = (state == ST_BYTE_WAIT) && romRsp.ack;
    assign cmdReset = regWrite && (regAddr == REG_STATUS_COMMAND) && regWdata[CMD_RESET_BIT];
    // RULE15 writes blocked
    assign writeProtect = statusCommand[CMD_ATTACH_BIT] && !loadBusy;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            usbSync <= SYNC_INIT;
            usbSeen <= 1'b0;
        end
        else
        begin
            usbSync <= {usbSync[1:0], usbResetPin};
            if (usbSync[1] == usbSync[2])
                usbSeen <= usbSync[2];
        end
    end

    // RULE4 trigger capture
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pending <= LOAD_NONE;
            porPending <= 1'b1;
        end
        else
        begin
            porPending <= 1'b0;
            if (porPending || cmdReset)
                // RULE5 full load
                pending <= LOAD_FULL;
            else if (softwareResetCmd || reloadCmd)
            begin
                // RULE7 ethernet only
                if (pending != LOAD_FULL)
                    pending <= LOAD_ETH;
            end
            else if (usbRise)
            begin
                // RULE6 mac only
                if (pending == LOAD_NONE)
                    pending <= LOAD_MAC;
            end
            else if (state == ST_IDLE)
                pending <= LOAD_NONE;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            kind <= LOAD_NONE;
            addr <= IMG_SIGNATURE;
            romReq <= '0;
            sigValid <= 1'b0;
            loadBusy <= 1'b1;
        end
        else
        begin
            romReq.req <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    loadBusy <= (pending != LOAD_NONE) || porPending;
                    if (pending != LOAD_NONE)
                    begin
                        kind <= pending;
                        state <= ST_SIG_REQ;
                    end
                end
                // RULE1 signature first
                ST_SIG_REQ:
                begin
                    romReq.req <= 1'b1;
                    romReq.addr <= IMG_SIGNATURE;
                    state <= ST_SIG_WAIT;
                end
                ST_SIG_WAIT:
                    if (romRsp.ack)
                    begin
                        sigValid <= (romRsp.data == SIGNATURE_VALUE);
                        // RULE2 skip on bad signature
                        if (romRsp.data == SIGNATURE_VALUE)
                        begin
                            addr <= IMG_MAC_FIRST;
                            state <= ST_BYTE_REQ;
                        end
                        else
                            state <= ST_DONE;
                    end
                ST_BYTE_REQ:
                begin
                    romReq.req <= 1'b1;
                    romReq.addr <= addr;
                    state <= ST_BYTE_WAIT;
                end
                ST_BYTE_WAIT:
                    if (romRsp.ack)
                    begin
                        if (addr == eca_last_addr(kind))
                            state <= ST_DONE;
                        else
                        begin
                            addr <= addr + 8'h01;
                            state <= ST_BYTE_REQ;
                        end
                    end
                // RULE18 release only when portion complete
                ST_DONE:
                begin
                    loadBusy <= 1'b0;
                    state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ethernet shadow, filled while loading
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            // RULE3 defaults
            ethShadow <= DEF_ETH_CFG;
        else if (cmdReset)
            ethShadow <= DEF_ETH_CFG;
        else if (byteTaken)
        begin
            if (addr >= IMG_MAC_FIRST && addr <= IMG_MAC_LAST)
                ethShadow.mac[8'(IMG_MAC_LAST - addr) * 8 +: 8] <= romRsp.data;
            else if (addr == IMG_FS_POLL)
                ethShadow.fsPoll <= romRsp.data;
            else if (addr == IMG_HS_POLL)
                ethShadow.hsPoll <= romRsp.data;
            else if (addr == IMG_CFG_FLAGS)
                ethShadow.cfgFlags <= romRsp.data;
            else if (addr == IMG_MAX_POWER && kind != LOAD_FULL)
                ethShadow.maxPower <= romRsp.data;
        end
    end

    // RULE18 publish ethernet values once load completes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ethCfg <= DEF_ETH_CFG;
        else if (cmdReset)
            ethCfg <= DEF_ETH_CFG;
        else if (state == ST_DONE)
            ethCfg <= ethShadow;
    end

    // hub registers: loaded only in a full load, software writable until protected
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            configByteThree <= DEF_CONFIG_BYTE_THREE;
            upstreamBoost <= DEF_BOOST;
            portFiveBoost <= DEF_BOOST;
            portsTwoToFourBoost <= DEF_BOOST;
            disSelf <= DEF_DISABLE;
            disBus <= DEF_DISABLE;
            remap12 <= DEF_REMAP;
            remap34 <= DEF_REMAP;
            remap5 <= DEF_REMAP;
        end
        else if (cmdReset)
        begin
            // RULE14 back to defaults
            configByteThree <= DEF_CONFIG_BYTE_THREE;
            upstreamBoost <= DEF_BOOST;
            portFiveBoost <= DEF_BOOST;
            portsTwoToFourBoost <= DEF_BOOST;
            disSelf <= DEF_DISABLE;
            disBus <= DEF_DISABLE;
            remap12 <= DEF_REMAP;
            remap34 <= DEF_REMAP;
            remap5 <= DEF_REMAP;
        end
        else if (byteTaken && kind == LOAD_FULL)
        begin
            case (addr)
                // RULE17 byte 28h
                IMG_CFG_THREE: configByteThree <= romRsp.data & 8'h08;
                // RULE9 disable masks
                IMG_DIS_SELF: disSelf <= romRsp.data;
                IMG_DIS_BUS: disBus <= romRsp.data;
                // RULE10 remap bytes
                IMG_REMAP_12: remap12 <= romRsp.data;
                IMG_REMAP_34: remap34 <= romRsp.data;
                IMG_REMAP_5: remap5 <= romRsp.data;
                IMG_BOOST_UP: upstreamBoost <= romRsp.data & 8'h03;
                IMG_BOOST_FIVE: portFiveBoost <= romRsp.data & 8'h03;
                IMG_BOOST_LOW: portsTwoToFourBoost <= romRsp.data & 8'hFC;
                default: ;
            endcase
        end
        else if (regWrite && !writeProtect)
        begin
            case (regAddr)
                REG_CONFIG_BYTE_THREE: configByteThree <= regWdata & 8'h08;
                REG_UPSTREAM_BOOST: upstreamBoost <= regWdata & 8'h03;
                REG_PORT_FIVE_BOOST: portFiveBoost <= regWdata & 8'h03;
                // RULE13 reserved low bits dropped
                REG_PORTS_TWO_TO_FOUR_BOOST: portsTwoToFourBoost <= regWdata & 8'hFC;
                default: ;
            endcase
        end
    end

    // status/command: reset bit never stored, so it reads 0 after the reset it caused
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // RULE16 default attach 1, one write allowed
            statusCommand <= DEF_STATUS_COMMAND;
            attachWritten <= 1'b0;
        end
        else if (regWrite && regAddr == REG_STATUS_COMMAND && !regWdata[CMD_RESET_BIT] && !attachWritten)
        begin
            statusCommand[CMD_ATTACH_BIT] <= regWdata[CMD_ATTACH_BIT];
            attachWritten <= 1'b1;
        end
    end

    // hub-facing outputs, held while loading, except usbAttach, which is driven low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            upstreamDriveBoost <= 2'b00;
            portFiveDriveBoost <= 2'b00;
            portFourDriveBoost <= 2'b00;
            portThreeDriveBoost <= 2'b00;
            portTwoDriveBoost <= 2'b00;
            portDisableMask <= DEF_DISABLE;
            portRemap <= '0;
            portRenumberSelect <= 1'b0;
            usbAttach <= 1'b0;
        end
        else if (!loadBusy)
        begin
            // RULE11 upstream boost to transceiver
            upstreamDriveBoost <= upstreamBoost[1:0];
            // RULE12 port five boost
            portFiveDriveBoost <= portFiveBoost[1:0];
            // RULE13 shared byte fields
            portFourDriveBoost <= portsTwoToFourBoost[7:6];
            portThreeDriveBoost <= portsTwoToFourBoost[5:4];
            portTwoDriveBoost <= portsTwoToFourBoost[3:2];
            portRenumberSelect <= configByteThree[RENUMBER_BIT];
            // RULE8 standard mode: mask only, hub closes the numbering gaps
            // RULE9 self or bus mask
            portDisableMask <= configByteThree[RENUMBER_BIT] ? DEF_DISABLE : (selfPowered ? disSelf : disBus);
            // RULE10 remap mode
            portRemap <= configByteThree[RENUMBER_BIT] ? {remap5, remap34, remap12} : '0;
            // RULE15 attach signalling
            usbAttach <= statusCommand[CMD_ATTACH_BIT];
        end
        else
            usbAttach <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            regRdata <= 8'h00;
        else if (regRead)
        begin
            case (regAddr)
                REG_CONFIG_BYTE_THREE: regRdata <= configByteThree;
                REG_UPSTREAM_BOOST: regRdata <= upstreamBoost;
                REG_PORT_FIVE_BOOST: regRdata <= portFiveBoost;
                REG_PORTS_TWO_TO_FOUR_BOOST: regRdata <= portsTwoToFourBoost;
                REG_STATUS_COMMAND: regRdata <= {6'b000000, statusCommand};
                REG_LOAD_STATUS: regRdata <= {6'b000000, sigValid, loadBusy};
                REG_PORT_MAP: regRdata <= portDisableMask;
                default: regRdata <= 8'h00;
            endcase
        end
        else
            regRdata <= 8'h00;
    end
endmodule : eca_autoload
`default_nettype wire

// >>> bench/eca_autoload_props.sv
// assertion checker for the configuration autoload block
`timescale 1ns/1ps
`default_nettype none
module eca_autoload_props
    import eca_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire eca_rom_req_s romReq,
    input wire eca_rom_rsp_s romRsp,
    input wire eca_eth_cfg_s ethCfg,
    input wire logic [1:0] upstreamDriveBoost,
    input wire logic [1:0] portFiveDriveBoost,
    input wire logic [7:0] portDisableMask,
    input wire logic [23:0] portRemap,
    input wire logic portRenumberSelect,
    input wire logic usbAttach,
    input wire logic loadBusy
);
    logic [7:0] lastAckData;
    logic [7:0] prevReqAddr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lastAckData <= 8'h00;
        else if (romRsp.ack)
            lastAckData <= romRsp.data;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prevReqAddr <= 8'h00;
        else if (romReq.req)
            prevReqAddr <= romReq.addr;
    end
    sequence s_load_start;
        $rose(loadBusy);
    endsequence
    sequence s_held_busy;
        loadBusy ##1 loadBusy;
    endsequence
    a_sig_checked: assert property (romReq.req && romReq.addr == IMG_MAC_FIRST |-> lastAckData == SIGNATURE_VALUE)
        else $error("image read went past a bad signature");
    a_addr_in_order: assert property (romReq.req && romReq.addr != 8'h00 |-> romReq.addr == prevReqAddr + 8'h01)
        else $error("image read out of order");
    a_one_request: assert property (romReq.req |=> !romReq.req)
        else $error("request longer than one cycle");
    a_attach_held: assert property (loadBusy |-> !usbAttach)
        else $error("attach shown during load");
    a_boost_frozen: assert property (s_held_busy |-> $stable(upstreamDriveBoost) && $stable(portFiveDriveBoost))
        else $error("boost changed during load");
    a_reset_defaults: assert property (!$past(rstn) |-> ethCfg == DEF_ETH_CFG && !usbAttach)
        else $error("defaults missing after reset");
    a_load_bounded: assert property (s_load_start |-> ##[1:1000] !loadBusy)
        else $error("load never finished");
    a_remap_mask_zero: assert property (portRenumberSelect |-> portDisableMask == 8'h00)
        else $error("mask shown in remap mode");
    a_std_remap_zero: assert property (!portRenumberSelect |-> portRemap == 24'h000000)
        else $error("remap shown in standard mode");
endmodule : eca_autoload_props
`default_nettype wire

// >>> bench/eca_rom_model.sv
// serial configuration memory model answering one image byte per request
`timescale 1ns/1ps
`default_nettype none
module eca_rom_model
    import eca_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire eca_rom_req_s romReq,
    input wire logic slow,
    output var eca_rom_rsp_s romRsp
);
    logic [7:0] mem [0:255];
    logic [7:0] addrHeld;
    logic pending;
    int waitCnt;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            romRsp <= '0;
            pending <= 1'b0;
            waitCnt <= 0;
            addrHeld <= 8'h00;
        end
        else
        begin
            romRsp.ack <= 1'b0;
            romRsp.data <= ~romRsp.data;
            if (romReq.req)
            begin
                pending <= 1'b1;
                addrHeld <= romReq.addr;
                waitCnt <= slow ? int'($urandom_range(4, 1)) : 0;
            end
            else if (pending && waitCnt > 0)
                waitCnt <= waitCnt - 1;
            else if (pending)
            begin
                pending <= 1'b0;
                romRsp.ack <= 1'b1;
                romRsp.data <= mem[addrHeld];
            end
        end
    end
endmodule : eca_rom_model
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench: memory image, register bus driver, read monitor
`timescale 1ns/1ps
`default_nettype none
module testbench
    import eca_pkg::*;
;
    logic clk, rstn, usbResetPin, softwareResetCmd, reloadCmd, selfPowered, slow, regWrite, regRead, rdSeen;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, oldFs;
    logic [1:0] upstreamDriveBoost, portFiveDriveBoost, portFourDriveBoost, portThreeDriveBoost, portTwoDriveBoost;
    logic [7:0] portDisableMask;
    logic [23:0] portRemap;
    logic portRenumberSelect, usbAttach, loadBusy;
    eca_rom_req_s romReq;
    eca_rom_rsp_s romRsp;
    eca_eth_cfg_s ethCfg;
    logic [7:0] expQ [$];
    int n_errors = 0;
    int n_checks = 0;

    eca_autoload dut_u (.clk(clk), .rstn(rstn), .usbResetPin(usbResetPin), .softwareResetCmd(softwareResetCmd),
        .reloadCmd(reloadCmd), .romReq(romReq), .romRsp(romRsp), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .selfPowered(selfPowered), .ethCfg(ethCfg),
        .upstreamDriveBoost(upstreamDriveBoost), .portFiveDriveBoost(portFiveDriveBoost),
        .portFourDriveBoost(portFourDriveBoost), .portThreeDriveBoost(portThreeDriveBoost),
        .portTwoDriveBoost(portTwoDriveBoost), .portDisableMask(portDisableMask), .portRemap(portRemap),
        .portRenumberSelect(portRenumberSelect), .usbAttach(usbAttach), .loadBusy(loadBusy));
    eca_rom_model rom_u (.clk(clk), .rstn(rstn), .romReq(romReq), .slow(slow), .romRsp(romRsp));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [95:0] img_run(input int a, input int n);
        img_run = '0;
        for (int i = 0; i < n; i++)
            img_run = {img_run[87:0], rom_u.mem[a + i]};
    endfunction : img_run

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
    endtask : reg_rd

    always @(negedge clk)
    begin
        if (rdSeen === 1'b1)
            check("regRdata", regRdata, expQ.pop_front());
        rdSeen = regRead;
    end

    task automatic wait_load();
        int k;
        k = 0;
        while (loadBusy !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        while (loadBusy !== 1'b0 && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 3000)
        begin
            n_errors++;
            $display("[FAIL] load wait ran out");
            give_verdict();
        end
        else
            repeat (2) @(negedge clk);
    endtask : wait_load

    task automatic pulse_cmd(input logic eth);
        @(posedge clk);
        softwareResetCmd <= eth;
        reloadCmd <= !eth;
        @(posedge clk);
        softwareResetCmd <= 1'b0;
        reloadCmd <= 1'b0;
    endtask : pulse_cmd

    task automatic fill_image(input logic [7:0] sig);
        for (int i = 0; i < 256; i++)
            rom_u.mem[i] = 8'($urandom);
        rom_u.mem[0] = sig;
        rom_u.mem[IMG_CFG_THREE] = 8'h00;
        rom_u.mem[IMG_BOOST_UP] &= 8'h03;
        rom_u.mem[IMG_BOOST_FIVE] &= 8'h03;
        rom_u.mem[IMG_BOOST_LOW] &= 8'hFC;
    endtask : fill_image

    task automatic check_boost(input logic [1:0] up, input logic [1:0] five, input logic [7:0] low);
        check("upstreamDriveBoost", upstreamDriveBoost, up);
        check("portFiveDriveBoost", portFiveDriveBoost, five);
        check("portFourDriveBoost", portFourDriveBoost, low[7:6]);
        check("portThreeDriveBoost", portThreeDriveBoost, low[5:4]);
        check("portTwoDriveBoost", portTwoDriveBoost, low[3:2]);
    endtask : check_boost

    initial
    begin
        void'($urandom(32'hC5C9));
        rstn = 1'b0;
        selfPowered = 1'b1;
        {usbResetPin, softwareResetCmd, reloadCmd, slow, regWrite, regRead, regAddr, regWdata} = '0;
        fill_image(~SIGNATURE_VALUE);
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        wait_load();
        check("ethCfg", ethCfg, DEF_ETH_CFG);
        check_boost(2'h0, 2'h0, 8'h00);
        fill_image(SIGNATURE_VALUE);
        slow = 1'b1;
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        wait_load();
        check("ethCfg", ethCfg[79:8], img_run(1, 9));
        check_boost(rom_u.mem[IMG_BOOST_UP][1:0], rom_u.mem[IMG_BOOST_FIVE][1:0], rom_u.mem[IMG_BOOST_LOW]);
        check("portRenumberSelect", portRenumberSelect, 1'b0);
        check("portDisableMask", portDisableMask, rom_u.mem[IMG_DIS_SELF]);
        check("usbAttach", usbAttach, 1'b1);
        reg_rd(REG_CONFIG_BYTE_THREE, 8'h00);
        reg_rd(REG_PORTS_TWO_TO_FOUR_BOOST, rom_u.mem[IMG_BOOST_LOW]);
        reg_rd(REG_STATUS_COMMAND, 8'h01);
        reg_rd(4'hF, 8'h00);
        reg_wr(REG_UPSTREAM_BOOST, ~rom_u.mem[IMG_BOOST_UP]);
        reg_rd(REG_UPSTREAM_BOOST, rom_u.mem[IMG_BOOST_UP]);
        reg_wr(REG_STATUS_COMMAND, 8'h00);
        reg_wr(REG_STATUS_COMMAND, 8'h01);
        reg_rd(REG_STATUS_COMMAND, 8'h00);
        @(negedge clk);
        check("usbAttach", usbAttach, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            reg_wr(REG_UPSTREAM_BOOST, 8'(c));
            reg_wr(REG_PORT_FIVE_BOOST, 8'(3 - c));
            reg_wr(REG_PORTS_TWO_TO_FOUR_BOOST, {2'(c), 2'(3 - c), 2'(c), 2'b00});
            repeat (2) @(negedge clk);
            check_boost(2'(c), 2'(3 - c), {2'(c), 2'(3 - c), 2'(c), 2'b00});
        end
        reg_wr(REG_CONFIG_BYTE_THREE, 8'h08);
        repeat (2) @(negedge clk);
        check("portRemap", portRemap, {rom_u.mem[IMG_REMAP_5], rom_u.mem[IMG_REMAP_34], rom_u.mem[IMG_REMAP_12]});
        reg_wr(REG_CONFIG_BYTE_THREE, 8'h00);
        selfPowered <= 1'b0;
        repeat (3) @(negedge clk);
        check("portDisableMask", portDisableMask, rom_u.mem[IMG_DIS_BUS]);
        oldFs = rom_u.mem[IMG_FS_POLL];
        fill_image(SIGNATURE_VALUE);
        @(posedge clk);
        usbResetPin <= 1'b1;
        wait_load();
        usbResetPin <= 1'b0;
        check("mac", ethCfg.mac, img_run(1, 6));
        check("fsPoll", ethCfg.fsPoll, oldFs);
        check_boost(2'h3, 2'h0, 8'hCC);
        fill_image(SIGNATURE_VALUE);
        pulse_cmd(1'b1);
        wait_load();
        check("ethCfg", ethCfg[79:8], img_run(1, 9));
        check("maxPower", ethCfg.maxPower, rom_u.mem[IMG_MAX_POWER]);
        check_boost(2'h3, 2'h0, 8'hCC);
        rom_u.mem[IMG_HS_POLL] = ~rom_u.mem[IMG_HS_POLL];
        slow = 1'b0;
        pulse_cmd(1'b0);
        wait_load();
        check("hsPoll", ethCfg.hsPoll, rom_u.mem[IMG_HS_POLL]);
        reg_wr(REG_STATUS_COMMAND, 8'h02);
        wait_load();
        check_boost(rom_u.mem[IMG_BOOST_UP][1:0], rom_u.mem[IMG_BOOST_FIVE][1:0], rom_u.mem[IMG_BOOST_LOW]);
        reg_rd(REG_STATUS_COMMAND, 8'h00);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule : testbench

bind eca_autoload eca_autoload_props props_u (.*);
`default_nettype wire
